/* design/gp_pkg.sv */
// Shared constants of the general-purpose pin port block: register map,
// field positions, reset values and bit masks.
// Assumes a byte-wide register port and three eight-bit pin ports.
`default_nettype none
package gp_pkg;
  localparam int NPORT = 3;
  localparam int NFIELD = 8;
  // Register offsets on the byte-wide register port.
  localparam logic [7:0] ADDR_P0 = 8'h00;
  localparam logic [7:0] ADDR_P1 = 8'h01;
  localparam logic [7:0] ADDR_P2 = 8'h02;
  localparam logic [7:0] ADDR_PEND = 8'h08;
  // Configuration field of port p lives at CFG_BASE + 8*p + field.
  localparam logic [7:0] CFG_BASE = 8'h10;
  localparam logic [7:0] CFG_LIMIT = 8'h18;
  // Configuration field positions, one bit per pin in each field.
  localparam logic [2:0] F_INT_EN = 3'h0;
  localparam logic [2:0] F_INT_LOW = 3'h1;
  localparam logic [2:0] F_TTL = 3'h2;
  localparam logic [2:0] F_SINK = 3'h3;
  localparam logic [2:0] F_OD = 3'h4;
  localparam logic [2:0] F_PU = 3'h5;
  localparam logic [2:0] F_OE = 3'h6;
  localparam logic [2:0] F_SPI = 3'h7;
  // Pins that exist on each port; the other positions are reserved.
  localparam logic [2:0][7:0] PIN_MASK = {8'hff, 8'hff, 8'h9a};
  // Pins that offer the strong sink option.
  localparam logic [2:0][7:0] SINK_MASK = {8'h00, 8'hf8, 8'h00};
  // Port 1 pins that can be handed to the serial interface.
  localparam logic [7:0] SPI_MASK = 8'h78;
  localparam int SPI_LO = 3;
  // Port 0 pins that share the port 0 interrupt (not the dedicated pair).
  localparam logic [7:0] SHARED0_MASK = 8'h82;
  localparam int PIN_EXT1 = 3;
  localparam int PIN_EXT2 = 4;
  // Pending register bit positions.
  localparam int PB_EXT1 = 0;
  localparam int PB_EXT2 = 1;
  localparam int PB_P0 = 2;
  localparam int PB_P1 = 3;
  localparam int PB_P2 = 4;
  localparam logic [4:0] PEND_RST = 5'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
endpackage
`default_nettype wire

/* design/gp_port.sv */
// General-purpose pin ports with data latches, per-pin configuration
// and edge-detected pin interrupts latched as pending flags.
// Assumes pins arrive asynchronously and that pad logic resolves the
// wire level from pin_out and pin_oe.
//
// Overview of operation
// - Data write latches bits; they reach only output-enabled pins.
// - Data read returns live pin levels, not the written latch.
// - Port 0 uses bits 7, 4, 3, 1; bits 4:3 are external interrupts.
// - Port 1 has eight pins; bits 6:3 may serve the serial interface.
// - Port 2 has eight data bits, 1:0 and 7:2.
// - After reset all pins are inputs with pull-ups on.
// - Interrupt enable lets a pin interrupt as input or output.
// - Interrupts are edge events; shared ones rearm when all go inactive.
// - An output pin driven active raises its enabled interrupt.
// - Polarity clear means active high, set means active low.
// - External interrupt pins: rising edge when clear, falling when set.
// - Threshold control selects TTL when set, CMOS by default.
// - Strong sink control selects high sink on capable pins.
// - Open drain: one floats, zero drives low; else push-pull.
// - Output enable turns driver on; pull-up enable connects pull-up.
// - Serial interface owns output enable while its use bit is set.
//
// Chosen here: the strobed register port.
`default_nettype none
module gp_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [2:0][7:0] pin_in,
  output logic [2:0][7:0] pin_out,
  output logic [2:0][7:0] pin_oe,
  output logic [2:0][7:0] pin_pu,
  output logic [2:0][7:0] pin_ttl,
  output logic [2:0][7:0] pin_sink_hi,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] spi_oe,
  output logic [4:0] irq_pending,
  output logic ext_irq_one,
  output logic ext_irq_two
);
  logic [2:0][7:0] data_q, next_data;
  logic [7:0] cfg [gp_pkg::NPORT][gp_pkg::NFIELD];
  logic [7:0] next_cfg [gp_pkg::NPORT][gp_pkg::NFIELD];
  logic [2:0][7:0] sync1, sync2, sync3, filt, next_filt;
  logic [2:0] quiet, next_quiet;
  logic [4:0] pend, next_pend;
  logic [7:0] next_rd;
  logic [2:0][7:0] next_out, next_oe;
  logic [7:0] cfg_idx;
  logic cfg_hit;
  logic [2:0][7:0] act;
  logic [4:0] set_ev;

  // Configuration window decode. The fourth port slot of the window is
  // left unmapped, so writes there are dropped and reads return zero.
  assign cfg_idx = addr - gp_pkg::CFG_BASE;
  assign cfg_hit = (addr >= gp_pkg::CFG_BASE) && (cfg_idx < gp_pkg::CFG_LIMIT)
                   && (cfg_idx[4:3] != 2'd3);

  // Input synchroniser: three stages, and a change counts only once the
  // second and third stages agree, which also rejects single-cycle glitches.
  always_comb begin
    for (int p = 0; p < gp_pkg::NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        next_filt[p][b] = (sync2[p][b] == sync3[p][b]) ? sync3[p][b]
                                                       : filt[p][b];
      end
    end
  end

  // Stages clear to low; enables are off after reset, so the first rise of
  // a pulled-up pin cannot raise an interrupt.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  // Latch and configuration writes; reserved positions never store.
  always_comb begin
    next_data = data_q;
    next_cfg = cfg;
    if (wr_en) begin
      for (int p = 0; p < gp_pkg::NPORT; p++) begin
        if (addr == gp_pkg::ADDR_P0 + 8'(p)) begin
          next_data[p] = wr_data & gp_pkg::PIN_MASK[p];
        end
      end
      if (cfg_hit) begin
        next_cfg[cfg_idx[4:3]][cfg_idx[2:0]] =
          wr_data & gp_pkg::PIN_MASK[cfg_idx[4:3]];
        if (cfg_idx[2:0] == gp_pkg::F_SINK) begin
          next_cfg[cfg_idx[4:3]][cfg_idx[2:0]] =
            wr_data & gp_pkg::SINK_MASK[cfg_idx[4:3]];
        end
        if (cfg_idx[2:0] == gp_pkg::F_SPI) begin
          next_cfg[cfg_idx[4:3]][cfg_idx[2:0]] =
            (cfg_idx[4:3] == 2'd1) ? (wr_data & gp_pkg::SPI_MASK) : 8'h00;
        end
      end
    end
  end

  // Pull-ups come up on for every pin and drivers come up off.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= {3{gp_pkg::DATA_RST}};
      for (int p = 0; p < gp_pkg::NPORT; p++) begin
        for (int f = 0; f < gp_pkg::NFIELD; f++) begin
          cfg[p][f] <= (3'(f) == gp_pkg::F_PU) ? gp_pkg::PIN_MASK[p]
                                               : 8'h00;
        end
      end
    end else begin
      data_q <= next_data;
      cfg <= next_cfg;
    end
  end

  // Pad drive is computed from the next state so that a write reaches
  // the pins on the same edge that stores it.
  always_comb begin
    for (int p = 0; p < gp_pkg::NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        // Open drain floats a one and pulls a zero low.
        next_out[p][b] = next_cfg[p][gp_pkg::F_OD][b] ? 1'b0
                                                      : next_data[p][b];
        next_oe[p][b] = next_cfg[p][gp_pkg::F_OE][b] &
                        (~next_cfg[p][gp_pkg::F_OD][b] |
                         ~next_data[p][b]);
      end
    end
    // While the use bit is set the serial interface drives these pins.
    for (int b = 0; b < 4; b++) begin
      if (next_cfg[1][gp_pkg::F_SPI][gp_pkg::SPI_LO + b]) begin
        next_out[1][gp_pkg::SPI_LO + b] = spi_out[b];
        next_oe[1][gp_pkg::SPI_LO + b] = spi_oe[b];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pu <= gp_pkg::PIN_MASK;
      pin_ttl <= '0;
      pin_sink_hi <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      for (int p = 0; p < gp_pkg::NPORT; p++) begin
        pin_pu[p] <= next_cfg[p][gp_pkg::F_PU];
        pin_ttl[p] <= next_cfg[p][gp_pkg::F_TTL];
        pin_sink_hi[p] <= next_cfg[p][gp_pkg::F_SINK];
      end
    end
  end

  // Interrupt events. The level seen is the pad itself, so a pin driven
  // as an output triggers its own interrupt as well.
  always_comb begin
    for (int p = 0; p < gp_pkg::NPORT; p++) begin
      act[p] = (next_filt[p] ^ cfg[p][gp_pkg::F_INT_LOW]) &
               cfg[p][gp_pkg::F_INT_EN];
    end
    act[0] = act[0] & gp_pkg::SHARED0_MASK;
    next_quiet = {~|act[2], ~|act[1], ~|act[0]};
    set_ev = '0;
    // Shared sources rearm only after every contributor went inactive.
    set_ev[gp_pkg::PB_P0] = quiet[0] & |act[0];
    set_ev[gp_pkg::PB_P1] = quiet[1] & |act[1];
    set_ev[gp_pkg::PB_P2] = quiet[2] & |act[2];
    // Dedicated pins: rising edge when polarity clear, falling when set.
    set_ev[gp_pkg::PB_EXT1] = cfg[0][gp_pkg::F_INT_EN][gp_pkg::PIN_EXT1] &
      (next_filt[0][gp_pkg::PIN_EXT1] != filt[0][gp_pkg::PIN_EXT1]) &
      (next_filt[0][gp_pkg::PIN_EXT1] ^
       cfg[0][gp_pkg::F_INT_LOW][gp_pkg::PIN_EXT1]);
    set_ev[gp_pkg::PB_EXT2] = cfg[0][gp_pkg::F_INT_EN][gp_pkg::PIN_EXT2] &
      (next_filt[0][gp_pkg::PIN_EXT2] != filt[0][gp_pkg::PIN_EXT2]) &
      (next_filt[0][gp_pkg::PIN_EXT2] ^
       cfg[0][gp_pkg::F_INT_LOW][gp_pkg::PIN_EXT2]);
    // Writing ones clears; a new event in the same cycle still wins.
    next_pend = pend;
    if (wr_en && addr == gp_pkg::ADDR_PEND) begin
      next_pend = pend & ~wr_data[4:0];
    end
    next_pend = next_pend | set_ev;
  end

  // Quiet starts high so the first active level after reset counts.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 3'h7;
      pend <= gp_pkg::PEND_RST;
    end else begin
      quiet <= next_quiet;
      pend <= next_pend;
    end
  end

  // The dedicated pins are presented as interrupt lines of their own.
  assign irq_pending = pend;
  assign ext_irq_one = pend[gp_pkg::PB_EXT1];
  assign ext_irq_two = pend[gp_pkg::PB_EXT2];

  // Read port. Data offsets return the filtered pad level, so firmware
  // sees what the pin really does, even when something outside fights it.
  always_comb begin
    next_rd = 8'h00;
    if (rd_en) begin
      for (int p = 0; p < gp_pkg::NPORT; p++) begin
        if (addr == gp_pkg::ADDR_P0 + 8'(p)) begin
          next_rd = filt[p] & gp_pkg::PIN_MASK[p];
        end
      end
      if (addr == gp_pkg::ADDR_PEND) begin
        next_rd = {3'h0, pend};
      end
      if (cfg_hit) begin
        next_rd = cfg[cfg_idx[4:3]][cfg_idx[2:0]];
      end
    end
  end

  // Read data stand for exactly one cycle and are zero otherwise.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd;
    end
  end

  // Checks watch the block's own state and outputs in its single domain.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_write_latch: assert property (
    wr_en && addr == gp_pkg::ADDR_P1 |=> data_q[1] == $past(wr_data))
    else $error("port 1 latch did not take the written byte");

  chk_read_live: assert property (
    rd_en && addr == gp_pkg::ADDR_P1 |=> rd_data == $past(filt[1]))
    else $error("port 1 read did not return the pin level");

  chk_reserved_zero: assert property (
    $past(rd_en) && $past(addr) == gp_pkg::ADDR_P0 |->
      (rd_data & ~gp_pkg::PIN_MASK[0]) == 8'h00)
    else $error("reserved port 0 bit read as one");

  chk_od_float: assert property (
    cfg[1][gp_pkg::F_OD][7] && cfg[1][gp_pkg::F_OE][7] && !wr_en
    |=> pin_oe[1][7] == !data_q[1][7] && !pin_out[1][7])
    else $error("open drain pin drove a one");

  chk_drive_latch: assert property (
    wr_en && addr == gp_pkg::ADDR_P1 && cfg[1][gp_pkg::F_OE][0] &&
    !cfg[1][gp_pkg::F_OD][0] |=> pin_oe[1][0] &&
    pin_out[1][0] == $past(wr_data[0]))
    else $error("driven port 1 pin did not follow the write");

  chk_pend_hold: assert property (
    pend[gp_pkg::PB_P1] && !(wr_en && addr == gp_pkg::ADDR_PEND)
    |=> pend[gp_pkg::PB_P1])
    else $error("port 1 pending flag dropped without a clear");

  chk_ext1_rise: assert property (
    cfg[0][gp_pkg::F_INT_EN][3] && !cfg[0][gp_pkg::F_INT_LOW][3] &&
    !filt[0][3] && next_filt[0][3] |=> pend[gp_pkg::PB_EXT1])
    else $error("rising edge on first external pin not latched");

  chk_irq_masked: assert property (
    !pend[gp_pkg::PB_EXT1] && !cfg[0][gp_pkg::F_INT_EN][3]
    |=> !pend[gp_pkg::PB_EXT1])
    else $error("disabled external interrupt became pending");

  chk_sync_settle: assert property (
    $stable(pin_in[0][7]) [*6] |-> filt[0][7] == pin_in[0][7])
    else $error("filtered pin level did not follow a steady pin");

  chk_spi_owns: assert property (
    cfg[1][gp_pkg::F_SPI][3] && !wr_en |=> pin_oe[1][3] == $past(spi_oe[0]))
    else $error("serial interface lost the output enable");

  // Covers for the main interrupt, read and clear scenarios.
  cov_ext2_fall: cover property (
    cfg[0][gp_pkg::F_INT_LOW][4] ##1 $rose(pend[gp_pkg::PB_EXT2]));
  cov_shared_p1: cover property ($rose(pend[gp_pkg::PB_P1]));
  cov_read_p2: cover property (rd_en && addr == gp_pkg::ADDR_P2 ##1 1'b1);
  cov_clear_pend: cover property (
    pend != 5'h00 && wr_en && addr == gp_pkg::ADDR_PEND ##1 pend == 5'h00);
endmodule
`default_nettype wire

/* tb/gp_pins.sv */
// Model of the pads and the board around the pin port block.
// Assumes the bench sets what the board drives on each pin.
`default_nettype none
module gp_pins (
  input wire logic clk_sys,
  input wire logic [2:0][7:0] pin_out,
  input wire logic [2:0][7:0] pin_oe,
  input wire logic [2:0][7:0] pin_pu,
  input wire logic [2:0][7:0] board_val,
  input wire logic [2:0][7:0] board_en,
  output logic [2:0][7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin changes every cycle, so a stale level is never read
  // back by luck.
  logic [2:0][7:0] drift = '0;
  always @(posedge clk_sys) begin
    drift <= ~drift;
  end
  // The pad driver beats the board, the board beats the pull-up.
  assign pin_in = (pin_oe & pin_out)
    | (~pin_oe & board_en & board_val)
    | (~pin_oe & ~board_en & (pin_pu | drift));
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the general-purpose pin port block.
// Assumes the pad model beside it resolves every pin level.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] port;
    logic [7:0] data;
    logic [7:0] oe;
    logic [7:0] bval;
    logic [7:0] exp;
  } gp_row_t;
  logic clk_sys;
  logic rst_n;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic [7:0] got;
  logic [2:0][7:0] pin_in, pin_out, pin_oe, pin_pu, pin_ttl, pin_sink_hi;
  logic [2:0][7:0] board_val, board_en;
  logic [3:0] spi_out, spi_oe;
  logic [4:0] irq_pending;
  logic ext_irq_one, ext_irq_two;
  int error_cnt;
  int n_checks;
  gp_row_t rows [3];

  gp_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .pin_ttl(pin_ttl), .pin_sink_hi(pin_sink_hi), .spi_out(spi_out),
    .spi_oe(spi_oe), .irq_pending(irq_pending),
    .ext_irq_one(ext_irq_one), .ext_irq_two(ext_irq_two));
  gp_pins pins_u (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .board_val(board_val), .board_en(board_en),
    .pin_in(pin_in));

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen,
        want);
    end
  endtask
  // Strobes drop one edge later, so back-to-back calls leave a gap.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    got = rd_data;
  endtask
  // Long enough for a pin change to pass the input synchroniser.
  task automatic wt;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    spi_out = 4'h0;
    spi_oe = 4'h0;
    board_val = '0;
    board_en = '1;
    error_cnt = 0;
    n_checks = 0;
    rows[0] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h9a};
    rows[1] = '{8'h01, 8'ha5, 8'h0f, 8'h3c, 8'h35};
    rows[2] = '{8'h02, 8'h5a, 8'hf0, 8'h0f, 8'h5f};
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    for (int p = 0; p < 3; p++) begin
      chk(pin_pu[p], (p == 0) ? 8'h9a : 8'hff);
      chk(pin_oe[p] | pin_ttl[p] | pin_sink_hi[p], 8'h00);
    end
    chk({3'h0, irq_pending}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    // Data rows: driven bits come back from enabled pins, board elsewhere.
    foreach (rows[i]) begin
      logic [1:0] p;
      p = rows[i].port[1:0];
      wr((rows[i].port << 3) + 8'h16, rows[i].oe);
      board_val[p] <= rows[i].bval;
      wr(rows[i].port, rows[i].data);
      wt();
      chk(pin_oe[p], rows[i].oe & gp_pkg::PIN_MASK[p]);
      chk(pin_out[p] & pin_oe[p], rows[i].data & pin_oe[p]);
      rd(rows[i].port);
      chk(got, rows[i].exp);
      wr((rows[i].port << 3) + 8'h16, 8'h00);
    end
    // Dedicated pins: rising edge when polarity clear, falling when set.
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, 8'h08 << k);
      wr(8'h08, 8'h1f);
      board_val[0][3+k] <= 1'b1;
      wt();
      chk({3'h0, irq_pending}, 8'h01 << k);
      chk({7'h0, (k == 1) ? ext_irq_two : ext_irq_one}, 8'h01);
      wr(8'h11, 8'h08 << k);
      wr(8'h08, 8'h1f);
      board_val[0][3+k] <= 1'b0;
      wt();
      chk({3'h0, irq_pending}, 8'h01 << k);
      wr(8'h10, 8'h00);
      wr(8'h11, 8'h00);
      wr(8'h08, 8'h1f);
      board_val[0][3+k] <= 1'b1;
      wt();
      chk({3'h0, irq_pending}, 8'h00);
    end
    // Firmware drives its own output pins to raise the shared interrupt.
    wr(8'h26, 8'h03);
    wr(8'h02, 8'h00);
    wr(8'h20, 8'h03);
    wr(8'h08, 8'h1f);
    wr(8'h02, 8'h01);
    wt();
    chk({3'h0, irq_pending}, 8'h10);
    wr(8'h08, 8'h10);
    wr(8'h02, 8'h03);
    wt();
    chk({3'h0, irq_pending}, 8'h00);
    wr(8'h02, 8'h00);
    wt();
    wr(8'h02, 8'h02);
    wt();
    chk({3'h0, irq_pending}, 8'h10);
    // Open drain: a one floats up to the pull-up, a zero pulls low.
    board_en[1][7] <= 1'b0;
    wr(8'h1c, 8'h80);
    wr(8'h1e, 8'h80);
    wr(8'h01, 8'h00);
    wt();
    chk({6'h0, pin_oe[1][7], pin_out[1][7]}, 8'h02);
    wr(8'h01, 8'h80);
    wt();
    chk({7'h0, pin_oe[1][7]}, 8'h00);
    rd(8'h01);
    chk(got & 8'h80, 8'h80);
    // The serial interface owns the driver while its use bit is set.
    wr(8'h1f, 8'h08);
    spi_out <= 4'h1;
    spi_oe <= 4'h1;
    wt();
    chk({6'h0, pin_oe[1][3], pin_out[1][3]}, 8'h03);
    // A general-purpose enable waits until the use bit is cleared.
    @(posedge clk_sys);
    spi_oe <= 4'h0;
    wr(8'h1e, 8'h88);
    wt();
    chk({7'h0, pin_oe[1][3]}, 8'h00);
    wr(8'h1f, 8'h00);
    wt();
    chk({7'h0, pin_oe[1][3]}, 8'h01);
    // Port 1 shared interrupt, active low: a falling pin raises it.
    @(posedge clk_sys);
    board_val[1][0] <= 1'b1;
    wr(8'h19, 8'h01);
    wr(8'h18, 8'h01);
    wr(8'h08, 8'h1f);
    board_val[1][0] <= 1'b0;
    wt();
    chk({3'h0, irq_pending}, 8'h08);
    wr(8'h1a, 8'hff);
    wr(8'h1b, 8'hff);
    wr(8'h1d, 8'h00);
    wt();
    chk(pin_ttl[1], 8'hff);
    chk(pin_sink_hi[1], 8'hf8);
    chk(pin_pu[1], 8'h00);
    rd(8'h30);
    chk(got, 8'h00);
    // A second reset puts every pin back to input with pull-up.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk(pin_pu[1], 8'hff);
    chk(pin_ttl[1] | pin_sink_hi[1] | pin_oe[1], 8'h00);
    chk({3'h0, irq_pending}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h1d);
    chk(got, 8'hff);
    final_report();
  end
endmodule
`default_nettype wire
